// [rtl/dmbc_top.sv]
// loop ratio, refresh request and supply detector register bank with apb slave
//
// Added by the designer: the APB register port.
module dmbc_top
  import dmbc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic WRITE_PROTECT,
  input wire logic LOOP_CLOSED,
  input wire logic [31:0] LOOP_VALUE_IN,
  output logic [5:0] COARSE_STEP_LIMIT,
  output logic [9:0] FINE_STEP_LIMIT,
  output logic [15:0] RATIO_FACTOR,
  output logic LOCK_LOSS,
  output logic FINE_PRESET,
  output logic [9:0] FINE_PRESET_VALUE,
  output logic [31:0] LOOP_VALUE,
  output logic LOOP_READY,
  input wire logic [5:0] USER_LEVEL,
  input wire logic [1:0] USER_ACTION,
  input wire logic USER_DEADBAND,
  input wire logic USER_ENABLE,
  input wire logic ULP_CLK_1K,
  input wire logic SUPPLY_BELOW,
  input wire logic STANDBY,
  output logic [5:0] DETECT_LEVEL,
  output logic DETECT_DEADBAND,
  output logic DETECT_ON,
  output logic SUPPLY_LOW,
  output logic BROWNOUT_RESET,
  output logic BROWNOUT_IRQ,
  output logic DETECT_SYNC_BUSY
);
  // ---------------- apb decode ----------------
  logic setup;
  logic access;
  logic wr_acc;
  logic hit_ratio;
  logic hit_sync;
  logic hit_det;
  logic mapped;
  logic wr_ok;

  assign setup = PSEL & ~PENABLE;
  assign access = PSEL & PENABLE;
  assign hit_ratio = (PADDR == OFF_RATIO);
  assign hit_sync = (PADDR == OFF_SYNC);
  assign hit_det = (PADDR == OFF_DET);
  assign mapped = hit_ratio | hit_sync | hit_det;
  assign wr_acc = access & PWRITE;
  assign wr_ok = wr_acc & mapped & ~WRITE_PROTECT;
  assign PREADY = 1'b1;
  assign PSLVERR = access & (~mapped | (PWRITE & WRITE_PROTECT));

  // ---------------- slow domain inputs ----------------
  logic [1:0] sync_in;
  logic [1:0] sync_out;
  logic ulp_s;
  logic below_s;
  logic ulp_prev_q;
  logic tick;

  assign sync_in = {ULP_CLK_1K, SUPPLY_BELOW};

  dmbc_sync2 #(
    .W(2)
  ) u_sync (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .async_in(sync_in),
    .sync_out(sync_out)
  );

  assign ulp_s = sync_out[1];
  assign below_s = sync_out[0];
  assign tick = ulp_s & ~ulp_prev_q;

  // ---------------- ratio register ----------------
  logic [31:0] ratio_q;
  logic [31:0] ratio_d;
  logic lock_loss_q;
  logic lock_loss_d;

  always_comb begin
    ratio_d = ratio_q;
    lock_loss_d = 1'b0;
    if (wr_ok && hit_ratio) begin
      ratio_d = PWDATA;
      lock_loss_d = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      ratio_q <= RATIO_RST;
      lock_loss_q <= 1'b0;
    end else begin
      ratio_q <= ratio_d;
      lock_loss_q <= lock_loss_d;
    end
  end

  // step limits are only handed to the loop while it runs closed
  assign COARSE_STEP_LIMIT = LOOP_CLOSED ? ratio_q[COARSE_LSB +: 6] : 6'h00;
  assign FINE_STEP_LIMIT = LOOP_CLOSED ? ratio_q[FINE_LSB +: 10] : 10'h000;
  assign RATIO_FACTOR = ratio_q[FACTOR_LSB +: 16];
  assign LOCK_LOSS = lock_loss_q;
  assign FINE_PRESET = lock_loss_q;
  assign FINE_PRESET_VALUE = FINE_MIDPOINT;

  // ---------------- loop value refresh ----------------
  dmbc_refresh_e rf_q;
  dmbc_refresh_e rf_d;
  logic [3:0] rf_cnt_q;
  logic [3:0] rf_cnt_d;
  logic [31:0] value_q;
  logic [31:0] value_d;
  logic ready_q;
  logic ready_d;
  logic refresh_req;

  assign refresh_req = wr_ok & hit_sync & PWDATA[REFRESH_BIT] & LOOP_CLOSED;

  always_comb begin
    rf_d = rf_q;
    rf_cnt_d = rf_cnt_q;
    value_d = value_q;
    ready_d = ready_q;
    case (rf_q)
      RF_IDLE: begin
        if (refresh_req) begin
          rf_d = RF_WAIT;
          rf_cnt_d = REFRESH_CYC;
          ready_d = 1'b0;
        end
      end
      RF_WAIT: begin
        if (rf_cnt_q <= 4'h1) begin
          rf_d = RF_DONE;
          value_d = LOOP_VALUE_IN;
        end else begin
          rf_cnt_d = rf_cnt_q - 4'h1;
        end
      end
      RF_DONE: begin
        rf_d = RF_IDLE;
        ready_d = 1'b1;
      end
      default: begin
        rf_d = RF_IDLE;
      end
    endcase
    // a ratio write drops the ready flag unless the refresh machine is in RF_DONE this cycle
    if (lock_loss_d && rf_q != RF_DONE) begin
      ready_d = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rf_q <= RF_IDLE;
      rf_cnt_q <= 4'h0;
      value_q <= 32'h00000000;
      ready_q <= 1'b0;
    end else begin
      rf_q <= rf_d;
      rf_cnt_q <= rf_cnt_d;
      value_q <= value_d;
      ready_q <= ready_d;
    end
  end

  assign LOOP_VALUE = value_q;
  assign LOOP_READY = ready_q;

  // ---------------- detector control ----------------
  dmbc_det_s shadow_q;
  dmbc_det_s shadow_d;
  dmbc_det_s active_q;
  dmbc_det_s active_d;
  logic pending_q;
  logic pending_d;
  logic boot_q;
  logic boot_d;
  logic sclk_stat_q;
  logic sclk_stat_d;
  logic [1:0] stable_q;
  logic [1:0] stable_d;
  logic ulp_prev_d;

  always_comb begin
    shadow_d = shadow_q;
    active_d = active_q;
    pending_d = pending_q;
    boot_d = 1'b1;
    sclk_stat_d = sclk_stat_q;
    stable_d = stable_q;
    ulp_prev_d = ulp_s;
    if (!boot_q) begin
      // user row values are taken once, on the first cycle after reset
      shadow_d.level = USER_LEVEL;
      shadow_d.action = USER_ACTION;
      shadow_d.deadband = USER_DEADBAND;
      shadow_d.enable = USER_ENABLE;
      active_d = shadow_d;
    end else begin
      // a write reaches the slow side at its next tick
      if (tick && pending_q) begin
        active_d = shadow_q;
        pending_d = 1'b0;
      end
      if (wr_ok && hit_det) begin
        shadow_d.level = PWDATA[LEVEL_LSB +: 6];
        shadow_d.presc = PWDATA[PRESC_LSB +: 4];
        shadow_d.sclk_on = PWDATA[SCLK_BIT];
        shadow_d.sampling = PWDATA[MODE_BIT];
        shadow_d.keep_in_standby = PWDATA[STDBY_BIT];
        shadow_d.action = PWDATA[ACTION_LSB +: 2];
        shadow_d.deadband = PWDATA[DEADBAND_BIT];
        shadow_d.enable = PWDATA[ENABLE_BIT];
        pending_d = 1'b1;
      end
      // sampling clock status lags the request by slow ticks
      if (tick) begin
        if (active_q.sclk_on) begin
          if (stable_q >= SCLK_STABLE_TICKS) begin
            sclk_stat_d = 1'b1;
          end else begin
            stable_d = stable_q + 2'h1;
          end
        end else begin
          stable_d = 2'h0;
          sclk_stat_d = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      shadow_q <= '0;
      active_q <= '0;
      pending_q <= 1'b0;
      boot_q <= 1'b0;
      sclk_stat_q <= 1'b0;
      stable_q <= 2'h0;
      ulp_prev_q <= 1'b0;
    end else begin
      shadow_q <= shadow_d;
      active_q <= active_d;
      pending_q <= pending_d;
      boot_q <= boot_d;
      sclk_stat_q <= sclk_stat_d;
      stable_q <= stable_d;
      ulp_prev_q <= ulp_prev_d;
    end
  end

  // ---------------- sampling and action ----------------
  dmbc_samp_if sif ();

  assign sif.tick = tick;
  assign sif.run = active_q.sclk_on;
  assign sif.presc = active_q.presc;

  dmbc_presc u_presc (
    .CLK(CLK),
    .RESET_N(RESET_N),
    .sif(sif.presc_side)
  );

  logic det_on;
  logic held_q;
  logic held_d;
  logic low_q;
  logic low_d;
  logic rst_q;
  logic rst_d;
  logic irq_q;
  logic irq_d;
  logic cmp;

  assign det_on = active_q.enable & (~STANDBY | active_q.keep_in_standby);

  always_comb begin
    held_d = held_q;
    if (sif.sample) begin
      held_d = below_s;
    end
    cmp = active_q.sampling ? held_q : below_s;
    low_d = det_on & cmp;
    rst_d = 1'b0;
    irq_d = 1'b0;
    if (low_d && !low_q) begin
      case (dmbc_action_e'(active_q.action))
        ACT_RESET: rst_d = 1'b1;
        ACT_IRQ: irq_d = 1'b1;
        default: begin
          rst_d = 1'b0;
          irq_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      held_q <= 1'b0;
      low_q <= 1'b0;
      rst_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      held_q <= held_d;
      low_q <= low_d;
      rst_q <= rst_d;
      irq_q <= irq_d;
    end
  end

  assign DETECT_LEVEL = active_q.level;
  assign DETECT_DEADBAND = active_q.deadband;
  assign DETECT_ON = det_on;
  assign SUPPLY_LOW = low_q;
  assign BROWNOUT_RESET = rst_q;
  assign BROWNOUT_IRQ = irq_q;
  assign DETECT_SYNC_BUSY = pending_q;

  // ---------------- read data ----------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] det_rd;

  always_comb begin
    det_rd = 32'h00000000;
    det_rd[LEVEL_LSB +: 6] = shadow_q.level;
    det_rd[PRESC_LSB +: 4] = shadow_q.presc;
    det_rd[SCLK_BIT] = sclk_stat_q;
    det_rd[MODE_BIT] = shadow_q.sampling;
    det_rd[STDBY_BIT] = shadow_q.keep_in_standby;
    det_rd[ACTION_LSB +: 2] = shadow_q.action;
    det_rd[DEADBAND_BIT] = shadow_q.deadband;
    det_rd[ENABLE_BIT] = shadow_q.enable;
    rdata_d = rdata_q;
    if (setup && !PWRITE) begin
      if (hit_ratio) begin
        rdata_d = ratio_q;
      end else if (hit_det) begin
        rdata_d = det_rd;
      end else begin
        rdata_d = 32'h00000000;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign PRDATA = rdata_q;
endmodule

// [shared/dmbc_pkg.sv]
// constants, field layout and types of the loop ratio and supply detector register bank
package dmbc_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_RATIO = 8'h2C;
  localparam logic [7:0] OFF_SYNC = 8'h30;
  localparam logic [7:0] OFF_DET = 8'h34;
  localparam logic [31:0] RATIO_RST = 32'h00000000;
  localparam int unsigned COARSE_LSB = 26;
  localparam int unsigned FINE_LSB = 16;
  localparam int unsigned FACTOR_LSB = 0;
  localparam int unsigned REFRESH_BIT = 7;
  localparam int unsigned LEVEL_LSB = 16;
  localparam int unsigned PRESC_LSB = 12;
  localparam int unsigned SCLK_BIT = 9;
  localparam int unsigned MODE_BIT = 8;
  localparam int unsigned STDBY_BIT = 6;
  localparam int unsigned ACTION_LSB = 3;
  localparam int unsigned DEADBAND_BIT = 2;
  localparam int unsigned ENABLE_BIT = 1;
  localparam logic [9:0] FINE_MIDPOINT = 10'h200;
  // system clock cycles from a refresh request to the captured value
  localparam int unsigned REFRESH_TIME_NS = 30;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam logic [3:0] REFRESH_CYC =
    4'((REFRESH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // slow ticks the sampling clock counts before the tick on which it reads as stable
  localparam logic [1:0] SCLK_STABLE_TICKS = 2'h2;
  localparam logic [15:0] PRESC_FULL = 16'hFFFF;
  localparam logic [3:0] PRESC_TOP = 4'hF;

  typedef enum logic [1:0] {
    ACT_NONE = 2'b00,
    ACT_RESET = 2'b01,
    ACT_IRQ = 2'b10,
    ACT_RSVD = 2'b11
  } dmbc_action_e;

  typedef enum logic [1:0] {
    RF_IDLE = 2'b00,
    RF_WAIT = 2'b01,
    RF_DONE = 2'b10
  } dmbc_refresh_e;

  typedef struct packed {
    logic [5:0] level;
    logic [3:0] presc;
    logic sclk_on;
    logic sampling;
    logic keep_in_standby;
    logic [1:0] action;
    logic deadband;
    logic enable;
  } dmbc_det_s;
endpackage

// [shared/dmbc_samp_if.sv]
// carrier between the detector control and its sampling prescaler
interface dmbc_samp_if;
  logic tick;
  logic run;
  logic [3:0] presc;
  logic sample;

  modport ctrl (output tick, output run, output presc, input sample);
  modport presc_side (input tick, input run, input presc, output sample);
endinterface

// [rtl/dmbc_sync2.sv]
// two flip-flop synchroniser for asynchronous levels
module dmbc_sync2 #(
  parameter int unsigned W = 1
) (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule

// [rtl/dmbc_presc.sv]
// sampling prescaler: one sample pulse per 2^(select+1) slow ticks
module dmbc_presc
  import dmbc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  dmbc_samp_if.presc_side sif
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic sample_q;
  logic sample_d;
  logic [15:0] last;

  always_comb begin
    last = PRESC_FULL >> (PRESC_TOP - sif.presc);
    cnt_d = cnt_q;
    sample_d = 1'b0;
    if (!sif.run) begin
      cnt_d = '0;
    end else if (sif.tick) begin
      if (cnt_q >= last) begin
        cnt_d = '0;
        sample_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RESET_N) begin
      cnt_q <= '0;
      sample_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      sample_q <= sample_d;
    end
  end

  assign sif.sample = sample_q;
endmodule

// [testbench/dmbc_top_props.sv]
// assertion checker for the loop ratio and supply detector register bank
module dmbc_top_props
  import dmbc_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic PSLVERR,
  input wire logic WRITE_PROTECT,
  input wire logic LOOP_CLOSED,
  input wire logic [5:0] COARSE_STEP_LIMIT,
  input wire logic [9:0] FINE_STEP_LIMIT,
  input wire logic [15:0] RATIO_FACTOR,
  input wire logic LOCK_LOSS,
  input wire logic FINE_PRESET,
  input wire logic [9:0] FINE_PRESET_VALUE,
  input wire logic LOOP_READY,
  input wire logic [5:0] DETECT_LEVEL,
  input wire logic DETECT_SYNC_BUSY,
  input wire logic BROWNOUT_RESET,
  input wire logic BROWNOUT_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic wr;
  // accepted write in its access cycle
  assign wr = PSEL && PENABLE && PWRITE && !WRITE_PROTECT;

  step_gate_a: assert property (
    !LOOP_CLOSED |-> COARSE_STEP_LIMIT == 6'h00 && FINE_STEP_LIMIT == 10'h000)
    else $error("step limits seen in open loop");
  lock_pulse_a: assert property (
    wr && PADDR == OFF_RATIO |=> LOCK_LOSS && FINE_PRESET ##1 !LOCK_LOSS)
    else $error("no single lock loss pulse after ratio write");
  preset_mid_a: assert property (
    FINE_PRESET |-> FINE_PRESET_VALUE == 10'h200)
    else $error("fine preset not at midpoint");
  factor_store_a: assert property (
    wr && PADDR == OFF_RATIO |=> RATIO_FACTOR == $past(PWDATA[15:0]))
    else $error("ratio factor not stored");
  refresh_ready_a: assert property (
    wr && PADDR == OFF_SYNC && PWDATA[REFRESH_BIT] && LOOP_CLOSED
    |=> !LOOP_READY ##[1:6] LOOP_READY)
    else $error("refresh did not end with ready");
  prot_err_a: assert property (
    PSEL && PENABLE && PWRITE && WRITE_PROTECT |-> PSLVERR)
    else $error("protected write not flagged");
  busy_set_a: assert property (
    wr && PADDR == OFF_DET |=> DETECT_SYNC_BUSY)
    else $error("detector write not marked busy");
  level_sync_a: assert property (
    $past(RESET_N, 2) && DETECT_LEVEL != $past(DETECT_LEVEL) |-> $past(DETECT_SYNC_BUSY))
    else $error("threshold changed without pending write");
  act_excl_a: assert property (!(BROWNOUT_RESET && BROWNOUT_IRQ))
    else $error("reset and interrupt both raised");
  irq_pulse_a: assert property (BROWNOUT_IRQ |=> !BROWNOUT_IRQ)
    else $error("interrupt pulse too long");
endmodule

bind dmbc_top dmbc_top_props dmbc_top_props_inst (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE,
  .PADDR, .PWDATA, .PSLVERR, .WRITE_PROTECT, .LOOP_CLOSED, .COARSE_STEP_LIMIT,
  .FINE_STEP_LIMIT, .RATIO_FACTOR, .LOCK_LOSS, .FINE_PRESET, .FINE_PRESET_VALUE, .LOOP_READY,
  .DETECT_LEVEL, .DETECT_SYNC_BUSY, .BROWNOUT_RESET, .BROWNOUT_IRQ);

// [testbench/test_dfll_multiplier_and_brownout_ctrl.sv]
// self-checking bench for the loop ratio and supply detector register bank
module test_dfll_multiplier_and_brownout_ctrl
  import dmbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK = 1'b0, RESET_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic WRITE_PROTECT = 1'b0, LOOP_CLOSED = 1'b0, ULP_CLK_1K = 1'b0, SUPPLY_BELOW = 1'b0;
  logic STANDBY = 1'b0, USER_DEADBAND, USER_ENABLE, PREADY, PSLVERR, LOCK_LOSS, FINE_PRESET;
  logic LOOP_READY, DETECT_DEADBAND, DETECT_ON, SUPPLY_LOW, BROWNOUT_RESET, BROWNOUT_IRQ;
  logic DETECT_SYNC_BUSY, er;
  logic [7:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0, LOOP_VALUE_IN, PRDATA, LOOP_VALUE, rd, mdl_det, d;
  logic [31:0] rnd = 32'h0000C49C;
  logic [5:0] USER_LEVEL, COARSE_STEP_LIMIT, DETECT_LEVEL;
  logic [1:0] USER_ACTION;
  logic [9:0] FINE_STEP_LIMIT, FINE_PRESET_VALUE;
  logic [15:0] RATIO_FACTOR;
  logic [3:0] cyc = 4'h0;
  int n_errors = 0, samples_checked = 0, nr, ni, i;

  dmbc_top dmbc_top_inst (.CLK, .RESET_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .WRITE_PROTECT, .LOOP_CLOSED, .LOOP_VALUE_IN, .COARSE_STEP_LIMIT,
    .FINE_STEP_LIMIT, .RATIO_FACTOR, .LOCK_LOSS, .FINE_PRESET, .FINE_PRESET_VALUE,
    .LOOP_VALUE, .LOOP_READY, .USER_LEVEL, .USER_ACTION, .USER_DEADBAND, .USER_ENABLE,
    .ULP_CLK_1K, .SUPPLY_BELOW, .STANDBY, .DETECT_LEVEL, .DETECT_DEADBAND, .DETECT_ON,
    .SUPPLY_LOW, .BROWNOUT_RESET, .BROWNOUT_IRQ, .DETECT_SYNC_BUSY);

  always #5 CLK = ~CLK;
  // slow clock sped up to one tick per 16 cycles
  always @(posedge CLK) begin
    cyc <= cyc + 4'h1;
    ULP_CLK_1K <= cyc[3];
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= wd;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  // detector write, model keeps only the writable bits
  task automatic dw(input logic [31:0] wd, input int n);
    apb(1'b1, OFF_DET, wd);
    mdl_det = wd & 32'h003FF35E;
    @(posedge CLK);
    for (i = 0; i < 100 && DETECT_SYNC_BUSY !== 1'b0; i++) @(posedge CLK);
    chk("sync busy", 32'h0, 32'(DETECT_SYNC_BUSY));
    repeat (n) @(posedge CLK);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge CLK);
    n_errors++;
    report_and_stop();
  end

  initial begin
    rnd = lfsr(rnd);
    {USER_LEVEL, USER_ACTION, USER_DEADBAND, USER_ENABLE} <= rnd[9:0];
    LOOP_VALUE_IN <= lfsr(rnd);
    repeat (12) @(posedge CLK);
    RESET_N <= 1'b1;
    repeat (2) @(posedge CLK);
    apb(1'b0, OFF_DET, 32'h0);
    mdl_det = {10'h0, USER_LEVEL, 11'h0, USER_ACTION, USER_DEADBAND, USER_ENABLE, 1'b0};
    chk("det startup", mdl_det, rd);
    chk("level out", 32'(USER_LEVEL), 32'(DETECT_LEVEL));
    apb(1'b0, OFF_RATIO, 32'h0);
    chk("ratio reset", 32'h0, rd);
    apb(1'b0, OFF_SYNC, 32'h0);
    chk("sync read", 32'h0, rd);
    apb(1'b0, 8'h38, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    LOOP_CLOSED <= 1'b1;
    repeat (4) begin
      rnd = lfsr(rnd);
      apb(1'b1, OFF_RATIO, rnd);
      apb(1'b0, OFF_RATIO, 32'h0);
      chk("ratio rd", rnd, rd);
      chk("coarse", 32'(rnd[31:26]), 32'(COARSE_STEP_LIMIT));
      chk("fine", 32'(rnd[25:16]), 32'(FINE_STEP_LIMIT));
      chk("factor", 32'(rnd[15:0]), 32'(RATIO_FACTOR));
    end
    LOOP_CLOSED <= 1'b0;
    @(posedge CLK);
    chk("open steps", 32'h0, {COARSE_STEP_LIMIT, FINE_STEP_LIMIT});
    WRITE_PROTECT <= 1'b1;
    apb(1'b1, OFF_RATIO, ~rnd);
    chk("prot err", 32'h1, 32'(er));
    WRITE_PROTECT <= 1'b0;
    apb(1'b0, OFF_RATIO, 32'h0);
    chk("prot keep", rnd, rd);
    LOOP_CLOSED <= 1'b1;
    apb(1'b1, OFF_SYNC, 32'h80);
    for (i = 0; i < 50 && LOOP_READY !== 1'b1; i++) @(posedge CLK);
    chk("loop ready", 32'h1, 32'(LOOP_READY));
    chk("loop value", LOOP_VALUE_IN, LOOP_VALUE);
    // detector off at its own threshold before the threshold moves
    dw({10'h0, USER_LEVEL, 16'h0000}, 0);
    // reserved bits written as ones while the detector is off
    dw(32'hFFD53FA1, 0);
    chk("level applied", 32'h15, 32'(DETECT_LEVEL));
    apb(1'b0, OFF_DET, 32'h0);
    chk("det shadow", mdl_det & ~32'h200, rd);
    repeat (100) @(posedge CLK);
    apb(1'b0, OFF_DET, 32'h0);
    chk("clk stable", mdl_det, rd);
    apb(1'b1, OFF_DET, 32'h00153100);
    apb(1'b0, OFF_DET, 32'h0);
    chk("clk stopping", 32'h00153300, rd);
    repeat (100) @(posedge CLK);
    apb(1'b0, OFF_DET, 32'h0);
    chk("clk stopped", 32'h00153100, rd);
    for (int a = 0; a < 4; a++) begin
      d = 32'h00150002 | (32'(a) << 3) | (32'(a % 2) << 2);
      dw(d, 2);
      chk("det on", 32'h1, 32'(DETECT_ON));
      chk("deadband", 32'(a % 2), 32'(DETECT_DEADBAND));
      SUPPLY_BELOW <= 1'b1;
      nr = 0;
      ni = 0;
      repeat (30) begin
        @(posedge CLK);
        nr += int'(BROWNOUT_RESET === 1'b1);
        ni += int'(BROWNOUT_IRQ === 1'b1);
      end
      chk("supply low", 32'h1, 32'(SUPPLY_LOW));
      chk("reset count", 32'(a == 1), 32'(nr));
      chk("irq count", 32'(a == 2), 32'(ni));
      SUPPLY_BELOW <= 1'b0;
      repeat (10) @(posedge CLK);
    end
    STANDBY <= 1'b1;
    @(posedge CLK);
    chk("standby off", 32'h0, 32'(DETECT_ON));
    dw(d | 32'h40, 2);
    chk("standby on", 32'h1, 32'(DETECT_ON));
    // sampling mode, divide by 2: the result moves only at samples 2 ticks of 16 cycles apart
    dw(32'h00150346, 2);
    SUPPLY_BELOW <= 1'b1;
    for (i = 0; i < 300 && SUPPLY_LOW !== 1'b1; i++) @(posedge CLK);
    chk("sampled low", 32'h1, 32'(SUPPLY_LOW));
    SUPPLY_BELOW <= 1'b0;
    ni = 0;
    do begin
      @(posedge CLK);
      ni++;
    end while (SUPPLY_LOW !== 1'b0 && ni < 300);
    chk("sample period", 32'(16 << 1), 32'(ni));
    report_and_stop();
  end
endmodule
